// ==== common/eeprom_read_pkg.sv ====
/*
 Shared constants, state encodings and carrier structs for the two-wire
 serial EEPROM read sequencer.
 Assumes a 50 MHz core clock and a separate link-side sampling clock.
*/
`default_nettype none
package eeprom_read_pkg;
   // array geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int WORD_COUNT = 1024;

   // device address byte: fixed upper nibble 1010
   localparam logic [3:0] DEV_CODE = 4'hA;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // reset values
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;
   localparam logic [ADDR_W-1:0] WORD_ADDR_RESET = 10'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [1:0] PAGE_RESET = 2'h0;

   // write-cycle busy time, counted on the core clock
   localparam int CLK_HZ = 50_000_000;
   localparam int WRITE_CYCLE_BUSY_TIME_MS = 5;
   localparam int WRITE_CYCLE_BUSY_CYCLES = WRITE_CYCLE_BUSY_TIME_MS * (CLK_HZ / 1000);
   localparam int BUSY_CNT_W = 18;
   typedef logic [BUSY_CNT_W-1:0] busy_cnt_t;

   typedef enum logic [2:0] {st_idle, st_rx, st_rx_ack, st_tx, st_tx_ack, st_wait} link_state_t;
   typedef enum logic [1:0] {kind_dev, kind_word, kind_data} byte_kind_t;

   // all link-domain state
   typedef struct packed {
      link_state_t state;
      byte_kind_t kind;
      logic scl_q;
      logic sda_q;
      logic [3:0] bit_cnt;
      logic [DATA_W-1:0] shift;
      logic rw;
      logic [1:0] page;
      logic [ADDR_W-1:0] word_addr;
      logic [ADDR_W-1:0] fetch_addr;
      logic [DATA_W-1:0] tx_data;
      logic req_tog;
      logic ack_q;
      logic acked;
      logic wrote;
      logic drive_low;
      logic stop_tog;
   } link_regs_t;

   localparam link_regs_t LINK_REGS_RESET = '{
      state: st_idle, kind: kind_dev, scl_q: 1'b1, sda_q: 1'b1,
      bit_cnt: BIT_CNT_RESET, shift: DATA_RESET, rw: 1'b0, page: PAGE_RESET,
      word_addr: WORD_ADDR_RESET, fetch_addr: WORD_ADDR_RESET, tx_data: DATA_RESET,
      req_tog: 1'b0, ack_q: 1'b0, acked: 1'b0, wrote: 1'b0, drive_low: 1'b0,
      stop_tog: 1'b0};

   // all core-domain state, array included
   typedef struct packed {
      logic [WORD_COUNT-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0] rd_data;
      logic req_q;
      logic ack_tog;
      logic stop_q;
      busy_cnt_t busy_cnt;
      logic busy;
   } core_regs_t;

   localparam core_regs_t CORE_REGS_RESET = '0;

   // array preload port
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } load_req_t;

   // open-drain data pin drive
   typedef struct packed {
      logic sda_out;
      logic sda_oe_n;
   } sda_drive_t;
endpackage
`default_nettype wire

// ==== hdl/bit_sync.sv ====
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a level or a toggle that is stable for at least two
 destination clock edges; no reset, so output is unknown for two edges.
*/
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
   parameter int W = 1
) (
   // destination clock
   input wire logic clk,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } sync_t;

   sync_t sync_reg;
   sync_t sync_next;

   // meta stage feeds only the held stage
   always_comb begin
      sync_next.meta = d;
      sync_next.held = sync_reg.meta;
   end

   always_ff @(posedge clk) begin
      sync_reg <= sync_next;
   end

   assign q = sync_reg.held;
endmodule
`default_nettype wire

// ==== hdl/serial_eeprom_read_sequencer.sv ====
/*
 Read-side protocol of a 1024 x 8 two-wire serial EEPROM slave.
 Link logic runs on link_clk and oversamples SCL/SDA; the array, the
 preload port and the write-cycle busy timer run on clk.
 Assumes link_clk is free running and at least ~16x the SCL rate, and that
 SDA is an open-drain wire resolved outside from sda_oe_n.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_read_sequencer #(
   parameter int BUSY_CYCLES = eeprom_read_pkg::WRITE_CYCLE_BUSY_CYCLES
) (
   // core clock domain
   input wire logic clk,
   input wire logic reset,
   // link clock and bus pins
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output var eeprom_read_pkg::sda_drive_t sda_drv,
   // hard-wired bank select strap
   input wire logic bank_select_input,
   // array preload, core domain
   input wire eeprom_read_pkg::load_req_t load_req,
   // write-cycle busy status, core domain
   output var logic busy
);
   localparam int FETCH_MAX = 8;

   eeprom_read_pkg::link_regs_t lnk_reg;
   eeprom_read_pkg::link_regs_t lnk_next;
   eeprom_read_pkg::core_regs_t core_reg;
   eeprom_read_pkg::core_regs_t core_next;

   wire logic [5:0] link_sync_q;
   wire logic [1:0] core_sync_q;
   wire logic link_rst;
   wire logic scl_s;
   wire logic sda_s;
   wire logic bank_s;
   wire logic busy_s;
   wire logic ack_s;
   wire logic req_s;
   wire logic stop_s;
   wire logic scl_rise;
   wire logic scl_fall;
   wire logic start_det;
   wire logic stop_det;
   wire logic byte_done;
   wire logic addr_match;
   wire logic ack_edge;
   logic load_byte;

   // reset, the bus pins, the bank strap, the core-domain busy level and the answer toggle are synchronised to link_clk before use
   bit_sync #(.W(6)) link_sync (
      .clk(link_clk),
      .d({reset, scl_in, sda_in, bank_select_input, core_reg.busy, core_reg.ack_tog}),
      .q(link_sync_q)
   );
   assign {link_rst, scl_s, sda_s, bank_s, busy_s, ack_s} = link_sync_q;

   bit_sync #(.W(2)) core_sync (
      .clk(clk),
      .d({lnk_reg.req_tog, lnk_reg.stop_tog}),
      .q(core_sync_q)
   );
   assign {req_s, stop_s} = core_sync_q;

   // bus events from the sampled lines
   assign scl_rise = scl_s & ~lnk_reg.scl_q;
   assign scl_fall = ~scl_s & lnk_reg.scl_q;
   assign start_det = scl_s & lnk_reg.scl_q & lnk_reg.sda_q & ~sda_s;
   assign stop_det = scl_s & lnk_reg.scl_q & ~lnk_reg.sda_q & sda_s;
   assign byte_done = scl_fall & (lnk_reg.bit_cnt == eeprom_read_pkg::BITS_PER_BYTE);
   assign ack_edge = ack_s ^ lnk_reg.ack_q;
   // busy device must not answer its address
   assign addr_match = (lnk_reg.shift[7:4] == eeprom_read_pkg::DEV_CODE)
      & (lnk_reg.shift[3] == bank_s) & ~busy_s;

   // link-side sequencer
   always_comb begin
      lnk_next = lnk_reg;
      load_byte = 1'b0;
      lnk_next.scl_q = scl_s;
      lnk_next.sda_q = sda_s;
      lnk_next.ack_q = ack_s;
      // rd_data is stable once the answer toggle has been seen
      if (ack_edge) begin
         lnk_next.tx_data = core_reg.rd_data;
      end
      if (link_rst) begin
         lnk_next = eeprom_read_pkg::LINK_REGS_RESET;
      end else if (start_det) begin
         // a repeated start turns a dummy write into a read
         lnk_next.state = eeprom_read_pkg::st_rx;
         lnk_next.kind = eeprom_read_pkg::kind_dev;
         lnk_next.bit_cnt = eeprom_read_pkg::BIT_CNT_RESET;
         lnk_next.drive_low = 1'b0;
         lnk_next.wrote = 1'b0;
      end else if (stop_det) begin
         lnk_next.state = eeprom_read_pkg::st_idle;
         lnk_next.drive_low = 1'b0;
         if (lnk_reg.wrote) begin
            lnk_next.stop_tog = ~lnk_reg.stop_tog;
         end
         lnk_next.wrote = 1'b0;
      end else begin
         case (lnk_reg.state)
            eeprom_read_pkg::st_idle, eeprom_read_pkg::st_wait: begin
               lnk_next.drive_low = 1'b0;
            end
            eeprom_read_pkg::st_rx: begin
               if (scl_rise) begin
                  lnk_next.shift = {lnk_reg.shift[6:0], sda_s};
                  lnk_next.bit_cnt = lnk_reg.bit_cnt + 4'h1;
               end else if (byte_done) begin
                  case (lnk_reg.kind)
                     eeprom_read_pkg::kind_dev: begin
                        if (addr_match) begin
                           lnk_next.drive_low = 1'b1;
                           lnk_next.state = eeprom_read_pkg::st_rx_ack;
                           lnk_next.rw = lnk_reg.shift[0];
                           lnk_next.page = lnk_reg.shift[2:1];
                           if (lnk_reg.shift[0]) begin
                              // fetch at the counter: current-address read
                              lnk_next.fetch_addr = lnk_reg.word_addr;
                              lnk_next.req_tog = ~lnk_reg.req_tog;
                           end
                        end else begin
                           lnk_next.state = eeprom_read_pkg::st_wait;
                        end
                     end
                     eeprom_read_pkg::kind_word: begin
                        // dummy write loads the word address
                        lnk_next.word_addr = {lnk_reg.page, lnk_reg.shift};
                        lnk_next.drive_low = 1'b1;
                        lnk_next.state = eeprom_read_pkg::st_rx_ack;
                     end
                     default: begin
                        // write data is acked and bumps the low nibble of the counter; programming lives elsewhere
                        lnk_next.drive_low = 1'b1;
                        lnk_next.state = eeprom_read_pkg::st_rx_ack;
                        lnk_next.wrote = 1'b1;
                        lnk_next.word_addr[3:0] = lnk_reg.word_addr[3:0] + 4'h1;
                     end
                  endcase
               end
            end
            eeprom_read_pkg::st_rx_ack: begin
               if (scl_fall) begin
                  lnk_next.drive_low = 1'b0;
                  lnk_next.bit_cnt = eeprom_read_pkg::BIT_CNT_RESET;
                  if (lnk_reg.kind == eeprom_read_pkg::kind_dev && lnk_reg.rw) begin
                     load_byte = 1'b1;
                  end else begin
                     lnk_next.state = eeprom_read_pkg::st_rx;
                     lnk_next.kind = (lnk_reg.kind == eeprom_read_pkg::kind_dev) ?
                        eeprom_read_pkg::kind_word : eeprom_read_pkg::kind_data;
                  end
               end
            end
            eeprom_read_pkg::st_tx: begin
               if (scl_rise) begin
                  lnk_next.bit_cnt = lnk_reg.bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (lnk_reg.bit_cnt == eeprom_read_pkg::BITS_PER_BYTE) begin
                     lnk_next.drive_low = 1'b0;
                     lnk_next.state = eeprom_read_pkg::st_tx_ack;
                     lnk_next.acked = 1'b0;
                  end else begin
                     lnk_next.shift = {lnk_reg.shift[6:0], 1'b0};
                     lnk_next.drive_low = ~lnk_reg.shift[6];
                  end
               end
            end
            eeprom_read_pkg::st_tx_ack: begin
               if (scl_rise) begin
                  if (!sda_s) begin
                     lnk_next.acked = 1'b1;
                  end else begin
                     lnk_next.state = eeprom_read_pkg::st_wait;
                  end
               end else if (scl_fall && lnk_reg.acked) begin
                  load_byte = 1'b1;
               end
            end
            default: begin
               lnk_next.state = eeprom_read_pkg::st_idle;
            end
         endcase
      end
      // send the prefetched byte, advance the counter and prefetch the next
      if (load_byte) begin
         lnk_next.state = eeprom_read_pkg::st_tx;
         lnk_next.bit_cnt = eeprom_read_pkg::BIT_CNT_RESET;
         lnk_next.shift = lnk_reg.tx_data;
         lnk_next.drive_low = ~lnk_reg.tx_data[7];
         lnk_next.word_addr = lnk_reg.word_addr + 10'h001;
         lnk_next.fetch_addr = lnk_reg.word_addr + 10'h001;
         lnk_next.req_tog = ~lnk_reg.req_tog;
      end
   end

   always_ff @(posedge link_clk) begin
      lnk_reg <= lnk_next;
   end

   // open drain: only ever pull low
   assign sda_drv = '{sda_out: 1'b0, sda_oe_n: ~lnk_reg.drive_low};

   // core side: array, fetch answers and busy timer
   always_comb begin
      core_next = core_reg;
      core_next.req_q = req_s;
      core_next.stop_q = stop_s;
      if (load_req.valid) begin
         core_next.mem[load_req.addr] = load_req.data;
      end
      // fetch_addr is held still while its request toggle is in flight
      if (req_s ^ core_reg.req_q) begin
         core_next.rd_data = core_reg.mem[lnk_reg.fetch_addr];
         core_next.ack_tog = ~core_reg.ack_tog;
      end
      if (stop_s ^ core_reg.stop_q) begin
         core_next.busy_cnt = eeprom_read_pkg::busy_cnt_t'(BUSY_CYCLES);
      end else if (core_reg.busy_cnt != '0) begin
         core_next.busy_cnt = core_reg.busy_cnt - 1'b1;
      end
      core_next.busy = (core_next.busy_cnt != '0);
      if (reset) begin
         core_next = eeprom_read_pkg::CORE_REGS_RESET;
      end
   end

   always_ff @(posedge clk) begin
      core_reg <= core_next;
   end

   assign busy = core_reg.busy;

   // checks on the link side and on the core-side busy timer
   property p_mismatch_nack;
      @(posedge link_clk) disable iff (link_rst)
      (lnk_reg.state == eeprom_read_pkg::st_rx && lnk_reg.kind == eeprom_read_pkg::kind_dev
         && byte_done && lnk_reg.shift[7:4] != eeprom_read_pkg::DEV_CODE)
      |=> (lnk_reg.state == eeprom_read_pkg::st_wait) ##1 sda_drv.sda_oe_n;
   endproperty
   a_mismatch_nack: assert property (p_mismatch_nack) else $error("address mismatch acked");
   property p_ack_low;
      @(posedge link_clk) disable iff (link_rst)
      lnk_reg.state == eeprom_read_pkg::st_rx_ack |-> !sda_drv.sda_oe_n;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("ack slot not driven low");
   property p_word_addr;
      @(posedge link_clk) disable iff (link_rst)
      (lnk_reg.state == eeprom_read_pkg::st_rx && lnk_reg.kind == eeprom_read_pkg::kind_word
         && byte_done)
      |=> lnk_reg.word_addr == {$past(lnk_reg.page), $past(lnk_reg.shift)};
   endproperty
   a_word_addr: assert property (p_word_addr) else $error("word address not formed");
   property p_read_start;
      @(posedge link_clk) disable iff (link_rst)
      (lnk_reg.state == eeprom_read_pkg::st_rx_ack && lnk_reg.kind == eeprom_read_pkg::kind_dev
         && lnk_reg.rw && scl_fall)
      |=> lnk_reg.state == eeprom_read_pkg::st_tx && lnk_reg.shift == $past(lnk_reg.tx_data)
         && sda_drv.sda_oe_n == $past(lnk_reg.tx_data[7]);
   endproperty
   a_read_start: assert property (p_read_start) else $error("read data not started");
   property p_incr;
      @(posedge link_clk) disable iff (link_rst)
      load_byte |=> lnk_reg.word_addr == $past(lnk_reg.word_addr) + 10'h001;
   endproperty
   a_incr: assert property (p_incr) else $error("address not advanced");
   property p_tx_release;
      @(posedge link_clk) disable iff (link_rst)
      lnk_reg.state == eeprom_read_pkg::st_tx_ack |-> sda_drv.sda_oe_n;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("sda held in master ack");
   property p_nack_wait;
      @(posedge link_clk) disable iff (link_rst)
      (lnk_reg.state == eeprom_read_pkg::st_tx_ack && scl_rise && sda_s)
      |=> lnk_reg.state == eeprom_read_pkg::st_wait && sda_drv.sda_oe_n;
   endproperty
   a_nack_wait: assert property (p_nack_wait) else $error("no wait after nack");
   property p_stop_idle;
      @(posedge link_clk) disable iff (link_rst)
      stop_det |=> lnk_reg.state == eeprom_read_pkg::st_idle && sda_drv.sda_oe_n;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not release");
   property p_busy_nack;
      @(posedge link_clk) disable iff (link_rst)
      (lnk_reg.state == eeprom_read_pkg::st_rx && lnk_reg.kind == eeprom_read_pkg::kind_dev
         && byte_done && busy_s)
      |=> lnk_reg.state == eeprom_read_pkg::st_wait;
   endproperty
   a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
   property p_fetch;
      @(posedge link_clk) disable iff (link_rst)
      $changed(lnk_reg.req_tog) |-> ##[1:FETCH_MAX] ack_edge;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch not answered");
   property p_busy_cause;
      @(posedge clk) disable iff (reset)
      $rose(core_reg.busy) |-> $past(stop_s ^ core_reg.stop_q);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without write stop");
   c_seq_read: cover property (@(posedge link_clk) disable iff (link_rst)
      lnk_reg.state == eeprom_read_pkg::st_tx_ack && scl_fall && lnk_reg.acked);
   c_wrap: cover property (@(posedge link_clk) disable iff (link_rst)
      load_byte && lnk_reg.word_addr == 10'h3FF);
   c_mismatch: cover property (@(posedge link_clk) disable iff (link_rst)
      lnk_reg.state == eeprom_read_pkg::st_rx && byte_done && !addr_match
      && lnk_reg.kind == eeprom_read_pkg::kind_dev);
   c_busy: cover property (@(posedge clk) disable iff (reset) $rose(core_reg.busy));
endmodule
`default_nettype wire

// ==== tb/bus_master_model.sv ====
/*
 Behavioural two-wire bus master that stands opposite the read sequencer.
 Assumes the bench resolves SDA as a wired AND with a pull-up and hands
 the resolved level back on sda_wire; SCL idles high between frames.
*/
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
   parameter int HALF = 8
) (
   // link clock that paces the bus phases
   input wire logic link_clk,
   // resolved data line and master drives
   input wire logic sda_wire,
   output var logic scl_out,
   output var logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge link_clk);
   endtask
   // one bit slot: data moves only while scl is low, sampled late in high
   task automatic bit_io(input logic b, output logic r);
      sda_out <= b;
      idle(HALF);
      scl_out <= 1'b1;
      idle(HALF);
      r = sda_wire;
      scl_out <= 1'b0;
      idle(2);
   endtask
   // start, also used as the repeated start of a random read
   task automatic start();
      sda_out <= 1'b1;
      idle(HALF);
      scl_out <= 1'b1;
      idle(HALF);
      sda_out <= 1'b0;
      idle(HALF);
      scl_out <= 1'b0;
      idle(2);
   endtask
   // stop leaves both lines high and the clock standing still
   task automatic stop();
      sda_out <= 1'b0;
      idle(HALF);
      scl_out <= 1'b1;
      idle(HALF);
      sda_out <= 1'b1;
      idle(HALF);
   endtask
   // address or word byte out, msb first, ack seen in ninth slot
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // data byte in; ack low while more is wanted, else left high
   task automatic read_byte(input logic more, output logic [7:0] d, output logic r9);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~more, r9);
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_serial_eeprom_read_sequencer.sv ====
/*
 Self-checking bench for the read sequencer: preloads the array with
 random bytes, mirrors it in a model and runs reads, refusals and a write.
 Assumes the bus master model and a shortened busy count.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_serial_eeprom_read_sequencer;
   localparam int BC = 2000;
   logic clk, link_clk, reset, bank, scl_m, sda_m, sda_wire, busy, ack, r9;
   eeprom_read_pkg::sda_drive_t sda_drv;
   eeprom_read_pkg::load_req_t load_req;
   int miscompares, checked, cycles, cnt_m, n, w;
   int seed;
   logic [7:0] mem_m [1024];
   logic [7:0] d;
   // wired-and data line with pull-up
   assign sda_wire = sda_m & (sda_drv.sda_oe_n | sda_drv.sda_out);
   bus_master_model #(.HALF(8)) m (.link_clk(link_clk), .sda_wire(sda_wire),
      .scl_out(scl_m), .sda_out(sda_m));
   serial_eeprom_read_sequencer #(.BUSY_CYCLES(BC)) uut (.clk(clk), .reset(reset),
      .link_clk(link_clk), .scl_in(scl_m), .sda_in(sda_wire), .sda_drv(sda_drv),
      .bank_select_input(bank), .load_req(load_req), .busy(busy));
   // clocks, link clock offset so the phases are unrelated
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end
   function automatic logic [7:0] dev(input logic [1:0] pg, input logic rw);
      return {4'hA, bank, pg, rw};
   endfunction
   task automatic addr_phase(input logic [7:0] b, input logic exp_ack);
      m.write_byte(b, ack);
      `CHK("ack", exp_ack, ack)
   endtask
   // reads after an acked read address, last byte nacked, then stop
   task automatic rd_seq(input int nb);
      for (int k = 0; k < nb; k++) begin
         m.read_byte(k < nb - 1, d, r9);
         `CHK("read_data", mem_m[cnt_m], d)
         cnt_m = (cnt_m + 1) % 1024;
      end
      `CHK("ninth_released", 1'b1, r9)
      m.stop();
      `CHK("released_after_stop", 1'b1, sda_drv.sda_oe_n)
   endtask
   task automatic cur_read(input int nb);
      m.start();
      addr_phase(dev(2'($random(seed)), 1'b1), 1'b1);
      rd_seq(nb);
   endtask
   task automatic rand_read(input logic [9:0] ad, input int nb);
      m.start();
      addr_phase(dev(ad[9:8], 1'b0), 1'b1);
      addr_phase(ad[7:0], 1'b1);
      cnt_m = ad;
      cur_read(nb);
   endtask
   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      seed = 32'h244194FA;
      reset = 1'b1;
      bank = 1'b1;
      load_req = '0;
      {miscompares, checked, cycles, cnt_m} = '0;
      // reset held longer than five cycles so the link side sees it too
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("busy_in_reset", 1'b0, busy)
      `CHK("sda_in_reset", 1'b1, sda_drv.sda_oe_n)
      @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 1024; i++) begin
         d = 8'($random(seed));
         mem_m[i] = d;
         @(posedge clk);
         load_req <= '{1'b1, 10'(i), d};
      end
      @(posedge clk);
      load_req <= '0;
      repeat (6) @(posedge link_clk);
      cur_read(2);
      rand_read(10'h3FE, 3);
      cur_read(1);
      rand_read(10'($random(seed)), 1);
      // refused address bytes: wrong fixed nibble, wrong bank bit
      for (int j = 0; j < 2; j++) begin
         m.start();
         addr_phase(dev(2'h0, 1'b1) ^ (j == 0 ? 8'h10 : 8'h08), 1'b0);
         m.stop();
      end
      // write with one data byte; low nibble rolls inside the page
      m.start();
      addr_phase(dev(2'h1, 1'b0), 1'b1);
      addr_phase(8'h2F, 1'b1);
      addr_phase(8'($random(seed)), 1'b1);
      cnt_m = 10'h120;
      // watch busy from before the stop so its whole length is counted
      fork
         begin
            {n, w} = '0;
            while (busy !== 1'b1 && w < 200) begin
               @(negedge clk);
               w++;
            end
            while (busy === 1'b1 && n < BC + 10) begin
               @(negedge clk);
               n++;
            end
            `CHK("busy_len", 1'b1, n >= BC - 1 && n <= BC)
         end
         begin
            m.stop();
            m.start();
            addr_phase(dev(2'h0, 1'b0), 1'b0);
            m.stop();
         end
      join
      repeat (4) @(posedge link_clk);
      m.start();
      addr_phase(dev(2'h0, 1'b0), 1'b1);
      cur_read(1);
      report_and_stop();
   end
endmodule
`default_nettype wire
